// *** p8m_pkg.sv ***
// package: register map, field positions, reset values and carriers for the port 8 pin control
package p8m_pkg;
	// register offsets
	localparam logic [7:0] OFS_PORT_DATA = 8'h00;
	localparam logic [7:0] OFS_PORT_DIR = 8'h01;
	localparam logic [7:0] OFS_CPU_MODE_A = 8'h02;
	localparam logic [7:0] OFS_SYNC_CTRL_ONE = 8'h03;
	localparam logic [7:0] OFS_SYNC_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_FIRST_ASYNC_CTRL = 8'h05;
	localparam logic [7:0] OFS_SECOND_ASYNC_CTRL = 8'h06;
	localparam logic [7:0] OFS_PIN_FUNC = 8'h07;
	// reset values
	localparam logic [7:0] RST_PORT_DATA = 8'h00;
	localparam logic [7:0] RST_PORT_DIR = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	// field positions
	localparam int ASYNC_TX_EN_BIT = 0;
	localparam int ASYNC_RX_EN_BIT = 1;
	localparam int ASYNC_CTS_BIT = 5;
	localparam int ASYNC_RTS_BIT = 6;
	localparam int SYNC1_CLK_BIT = 2;
	localparam int SYNC1_TX_BIT = 3;
	localparam int SYNC1_READY_BIT = 4;
	localparam int SYNC1_INT_CLK_BIT = 6;
	localparam int SYNC2_RX_BIT = 2;
	localparam int MODE_LOCK_BIT = 1;
	// processor modes held in cpu_mode_reg_a bits 1:0
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_MICRO = 2'h2;
	// timing
	localparam int CLOCK_HZ = 10000000;
	localparam int RESET_MIN_NS = 2000;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
	localparam int PORT_WIDTH = 8;

	// asynchronous unit towards the pins
	typedef struct packed {
		logic txd;
		logic rts;
	} p8m_async_out_t;
	// pins towards an asynchronous unit
	typedef struct packed {
		logic rxd;
		logic cts;
	} p8m_async_in_t;
	// clocked serial unit towards the pins
	typedef struct packed {
		logic readyOut;
		logic clkOut;
		logic txd;
	} p8m_sio_out_t;
	// pins towards the clocked serial unit
	typedef struct packed {
		logic readyIn;
		logic clkIn;
		logic rxd;
	} p8m_sio_in_t;
	// cpu core bus activity
	typedef struct packed {
		logic dmaBusy;
		logic stopOrWait;
		logic opFetch;
		logic cpuRead;
		logic cpuWrite;
	} p8m_core_t;
	// external bus control pins
	typedef struct packed {
		logic oe;
		logic dmaActive;
		logic phiOut;
		logic opcode_fetch_pulse;
		logic rdN;
		logic wrN;
	} p8m_bus_pins_t;
endpackage

// *** p8m_pin_ctrl.sv ***
// module: port 8 pin function selection and external bus control pins
// Summary of operation
// RULE1 - port 8 eight general pins in every mode
// RULE2 - second async transmit owns pin 0 first
// RULE3 - else ctrl one bit 4 gives ready output
// RULE4 - ready in slave mode is an input
// RULE5 - second async receive owns pin 1 first
// RULE6 - else ctrl one bit 2 gives shift clock
// RULE7 - pin 2 clear-to-send, else clocked receive
// RULE8 - pin 3 request-to-send, else clocked transmit
// RULE9 - first async transmit drives pin 4
// RULE10 - first async receive samples pin 5
// RULE11 - first async bit 5 gives pin 6 cts
// RULE12 - first async bit 6 gives pin 7 rts
// RULE13 - strap high microprocessor, low single chip
// RULE14 - mode bits writable, bit 1 locked by strap
// RULE15 - reset held low at least two microseconds
// RULE16 - dma output high during dma transfer
// RULE17 - clock output, held high on stop/wait
// RULE18 - sync pulse half clock per opcode fetch
// RULE19 - read and write strobes low on access
// RULE20 - peripheral function overrides direction register
// RULE21 - unused pins follow latch and direction
//
// The implementer's own choices: the plain strobed port and the register addresses.
module p8m_pin_ctrl
	import p8m_pkg::*;
#(
	parameter int PORT_W = p8m_pkg::PORT_WIDTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// port 8 pins
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe,
	// mode strap pin
	input wire logic modeStrapPin,
	// serial units
	input wire p8m_pkg::p8m_async_out_t firstAsyncOut,
	input wire p8m_pkg::p8m_async_out_t secondAsyncOut,
	input wire p8m_pkg::p8m_sio_out_t sioOut,
	output p8m_pkg::p8m_async_in_t firstAsyncIn,
	output p8m_pkg::p8m_async_in_t secondAsyncIn,
	output p8m_pkg::p8m_sio_in_t sioIn,
	// control registers handed to the serial units, and the processor mode
	output logic [7:0] syncCtrlOne,
	output logic [7:0] syncCtrlTwo,
	output logic [7:0] firstAsyncCtrl,
	output logic [7:0] secondAsyncCtrl,
	output logic [1:0] cpuMode,
	// cpu core and external bus pins
	input wire p8m_pkg::p8m_core_t core,
	output p8m_pkg::p8m_bus_pins_t busPins
);
	import p8m_pkg::*;

	typedef struct packed {
		logic [7:0] dat;
		logic [7:0] dir;
		logic [1:0] mode;
		logic [7:0] sc1;
		logic [7:0] sc2;
		logic [7:0] u1c;
		logic [7:0] u2c;
		logic [1:0] strapSync;
		logic [7:0] pinMeta;
		logic [7:0] pinSync;
		logic [7:0] funcSel;
		logic [7:0] rdData;
		logic [7:0] pinOut;
		logic [7:0] pinOe;
		p8m_async_in_t u1In;
		p8m_async_in_t u2In;
		p8m_sio_in_t sioIn;
		p8m_bus_pins_t bus;
	} p8m_state_t;

	p8m_state_t st_ff;
	p8m_state_t nxt_st;
	logic extMode;
	logic slaveMode;
	logic [7:0] pinReadBack;

	// the pin map is fixed at eight pins; refuse other widths at elaboration
	if (PORT_W != 8) begin
		$error("p8m_pin_ctrl serves an eight-pin port only");
	end

	assign extMode = (st_ff.mode != MODE_SINGLE);
	// the clocked serial unit is slave when its clock comes from outside
	assign slaveMode = ~st_ff.sc1[SYNC1_INT_CLK_BIT];
	assign pinReadBack = (st_ff.dir & st_ff.dat) | (~st_ff.dir & st_ff.pinSync);

	always_comb begin
		nxt_st = st_ff;
		// pins and strap are asynchronous; second stage alone feeds logic
		nxt_st.pinMeta = pinIn;
		nxt_st.pinSync = st_ff.pinMeta;
		nxt_st.strapSync = {st_ff.strapSync[0], modeStrapPin};
		nxt_st.rdData = 8'h00;

		// register writes
		if (regWrite) begin
			case (regAddr)
				OFS_PORT_DATA: begin
					nxt_st.dat = regWrData;
				end
				OFS_PORT_DIR: begin
					nxt_st.dir = regWrData;
				end
				OFS_CPU_MODE_A: begin
					nxt_st.mode[0] = regWrData[0]; // RULE14
					if (!st_ff.strapSync[1]) begin
						nxt_st.mode[MODE_LOCK_BIT] = regWrData[MODE_LOCK_BIT]; // RULE14
					end
				end
				OFS_SYNC_CTRL_ONE: begin
					nxt_st.sc1 = regWrData;
				end
				OFS_SYNC_CTRL_TWO: begin
					nxt_st.sc2 = regWrData;
				end
				OFS_FIRST_ASYNC_CTRL: begin
					nxt_st.u1c = regWrData;
				end
				OFS_SECOND_ASYNC_CTRL: begin
					nxt_st.u2c = regWrData;
				end
				default: begin
				end
			endcase
		end

		// register reads, answered in the next cycle only
		if (regRead) begin
			case (regAddr)
				OFS_PORT_DATA: nxt_st.rdData = pinReadBack;
				OFS_PORT_DIR: nxt_st.rdData = st_ff.dir;
				OFS_CPU_MODE_A: nxt_st.rdData = {6'h00, st_ff.mode};
				OFS_SYNC_CTRL_ONE: nxt_st.rdData = st_ff.sc1;
				OFS_SYNC_CTRL_TWO: nxt_st.rdData = st_ff.sc2;
				OFS_FIRST_ASYNC_CTRL: nxt_st.rdData = st_ff.u1c;
				OFS_SECOND_ASYNC_CTRL: nxt_st.rdData = st_ff.u2c;
				OFS_PIN_FUNC: nxt_st.rdData = st_ff.funcSel;
				default: nxt_st.rdData = 8'h00;
			endcase
		end

		// default: every pin is plain port i/o
		for (int i = 0; i < 8; i++) begin
			nxt_st.pinOut[i] = st_ff.dat[i]; // RULE21 RULE1
			nxt_st.pinOe[i] = st_ff.dir[i]; // RULE21 RULE1
		end
		nxt_st.funcSel = 8'h00;
		// inputs of the units idle high when their pin is elsewhere
		nxt_st.u1In = '1;
		nxt_st.u2In = '1;
		nxt_st.sioIn = '1;

		// pin 0: second async transmit over clocked serial ready
		if (st_ff.u2c[ASYNC_TX_EN_BIT]) begin
			nxt_st.pinOut[0] = secondAsyncOut.txd; // RULE2
			nxt_st.pinOe[0] = 1'b1; // RULE2 RULE20
			nxt_st.funcSel[0] = 1'b1;
		end else if (st_ff.sc1[SYNC1_READY_BIT]) begin
			nxt_st.funcSel[0] = 1'b1;
			if (slaveMode) begin
				nxt_st.pinOe[0] = 1'b0; // RULE4 RULE20
				nxt_st.sioIn.readyIn = st_ff.pinSync[0]; // RULE4
			end else begin
				nxt_st.pinOut[0] = sioOut.readyOut; // RULE3
				nxt_st.pinOe[0] = 1'b1; // RULE3 RULE20
			end
		end

		// pin 1: second async receive over shift clock
		if (st_ff.u2c[ASYNC_RX_EN_BIT]) begin
			nxt_st.pinOe[1] = 1'b0; // RULE5 RULE20
			nxt_st.u2In.rxd = st_ff.pinSync[1]; // RULE5
			nxt_st.funcSel[1] = 1'b1;
		end else if (st_ff.sc1[SYNC1_CLK_BIT]) begin
			nxt_st.funcSel[1] = 1'b1;
			if (st_ff.sc1[SYNC1_INT_CLK_BIT]) begin
				nxt_st.pinOut[1] = sioOut.clkOut; // RULE6
				nxt_st.pinOe[1] = 1'b1; // RULE6 RULE20
			end else begin
				nxt_st.pinOe[1] = 1'b0; // RULE6 RULE20
				nxt_st.sioIn.clkIn = st_ff.pinSync[1]; // RULE6
			end
		end

		// pin 2: second async clear-to-send over clocked receive
		if (st_ff.u2c[ASYNC_CTS_BIT]) begin
			nxt_st.pinOe[2] = 1'b0; // RULE7 RULE20
			nxt_st.u2In.cts = st_ff.pinSync[2]; // RULE7
			nxt_st.funcSel[2] = 1'b1;
		end else if (st_ff.sc2[SYNC2_RX_BIT]) begin
			nxt_st.pinOe[2] = 1'b0; // RULE7 RULE20
			nxt_st.sioIn.rxd = st_ff.pinSync[2]; // RULE7
			nxt_st.funcSel[2] = 1'b1;
		end

		// pin 3: second async request-to-send over clocked transmit
		if (st_ff.u2c[ASYNC_RTS_BIT]) begin
			nxt_st.pinOut[3] = secondAsyncOut.rts; // RULE8
			nxt_st.pinOe[3] = 1'b1; // RULE8 RULE20
			nxt_st.funcSel[3] = 1'b1;
		end else if (st_ff.sc1[SYNC1_TX_BIT]) begin
			nxt_st.pinOut[3] = sioOut.txd; // RULE8
			nxt_st.pinOe[3] = 1'b1; // RULE8 RULE20
			nxt_st.funcSel[3] = 1'b1;
		end

		// pins 4 to 7: first async unit
		if (st_ff.u1c[ASYNC_TX_EN_BIT]) begin
			nxt_st.pinOut[4] = firstAsyncOut.txd; // RULE9
			nxt_st.pinOe[4] = 1'b1; // RULE9 RULE20
			nxt_st.funcSel[4] = 1'b1;
		end
		if (st_ff.u1c[ASYNC_RX_EN_BIT]) begin
			nxt_st.pinOe[5] = 1'b0; // RULE10 RULE20
			nxt_st.u1In.rxd = st_ff.pinSync[5]; // RULE10
			nxt_st.funcSel[5] = 1'b1;
		end
		if (st_ff.u1c[ASYNC_CTS_BIT]) begin
			nxt_st.pinOe[6] = 1'b0; // RULE11 RULE20
			nxt_st.u1In.cts = st_ff.pinSync[6]; // RULE11
			nxt_st.funcSel[6] = 1'b1;
		end
		if (st_ff.u1c[ASYNC_RTS_BIT]) begin
			nxt_st.pinOut[7] = firstAsyncOut.rts; // RULE12
			nxt_st.pinOe[7] = 1'b1; // RULE12 RULE20
			nxt_st.funcSel[7] = 1'b1;
		end

		// external bus control pins; idle levels outside bus modes
		nxt_st.bus.oe = extMode;
		if (extMode) begin
			nxt_st.bus.dmaActive = core.dmaBusy; // RULE16
			// divide by two; a stopped core parks the clock high
			if (core.stopOrWait) begin
				nxt_st.bus.phiOut = 1'b1; // RULE17
			end else begin
				nxt_st.bus.phiOut = ~st_ff.bus.phiOut; // RULE17
			end
			// one system clock is half a period of the divided clock
			nxt_st.bus.opcode_fetch_pulse = core.opFetch; // RULE18
			nxt_st.bus.rdN = ~core.cpuRead; // RULE19
			nxt_st.bus.wrN = ~core.cpuWrite; // RULE19
		end else begin
			nxt_st.bus.dmaActive = 1'b0;
			nxt_st.bus.phiOut = 1'b1;
			nxt_st.bus.opcode_fetch_pulse = 1'b0;
			nxt_st.bus.rdN = 1'b1;
			nxt_st.bus.wrN = 1'b1;
		end

		if (srst) begin
			nxt_st.dat = RST_PORT_DATA;
			nxt_st.dir = RST_PORT_DIR;
			nxt_st.sc1 = RST_CTRL;
			nxt_st.sc2 = RST_CTRL;
			nxt_st.u1c = RST_CTRL;
			nxt_st.u2c = RST_CTRL;
			// strap keeps sampling through reset; the last sample wins
			nxt_st.mode = st_ff.strapSync[1] ? MODE_MICRO : MODE_SINGLE; // RULE13
			nxt_st.funcSel = 8'h00;
			nxt_st.rdData = 8'h00;
			nxt_st.pinOut = 8'h00;
			nxt_st.pinOe = 8'h00;
			nxt_st.u1In = '1;
			nxt_st.u2In = '1;
			nxt_st.sioIn = '1;
			nxt_st.bus = '0;
			nxt_st.bus.phiOut = 1'b1;
			nxt_st.bus.rdN = 1'b1;
			nxt_st.bus.wrN = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		st_ff <= nxt_st;
	end

	assign regRdData = st_ff.rdData;
	assign pinOut = st_ff.pinOut;
	assign pinOe = st_ff.pinOe;
	assign firstAsyncIn = st_ff.u1In;
	assign secondAsyncIn = st_ff.u2In;
	assign sioIn = st_ff.sioIn;
	assign syncCtrlOne = st_ff.sc1;
	assign syncCtrlTwo = st_ff.sc2;
	assign firstAsyncCtrl = st_ff.u1c;
	assign secondAsyncCtrl = st_ff.u2c;
	assign cpuMode = st_ff.mode;
	assign busPins = st_ff.bus;
endmodule

// *** p8m_chk.sv ***
// checker: port level properties of the port 8 pin control
module p8m_chk
	import p8m_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// pins and units
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic modeStrapPin,
	input wire p8m_pkg::p8m_async_out_t firstAsyncOut,
	input wire p8m_pkg::p8m_async_out_t secondAsyncOut,
	input wire p8m_pkg::p8m_sio_out_t sioOut,
	input wire logic [7:0] syncCtrlOne,
	input wire logic [7:0] firstAsyncCtrl,
	input wire logic [7:0] secondAsyncCtrl,
	input wire logic [1:0] cpuMode,
	// core and bus pins
	input wire p8m_pkg::p8m_core_t core,
	input wire p8m_pkg::p8m_bus_pins_t busPins
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	wire busMode = cpuMode != 2'h0;
	sequence fetchSeq;
		busMode && core.opFetch ##1 busMode && !core.opFetch;
	endsequence
	// four stable strap cycles so the synchronised copy is surely high
	sequence lockedWrite;
		modeStrapPin [*4] ##0 regWrite && regAddr == OFS_CPU_MODE_A;
	endsequence
	tx_two_a: assert property (secondAsyncCtrl[0] |=> pinOe[0] && pinOut[0] == $past(secondAsyncOut.txd))
		else $error("pin 0 lost second transmit");
	ready_pin_a: assert property (!secondAsyncCtrl[0] && syncCtrlOne[4] |=> pinOe[0] == $past(syncCtrlOne[6])
		&& (!pinOe[0] || pinOut[0] == $past(sioOut.readyOut))) else $error("pin 0 ready wrong");
	shift_clk_a: assert property (!secondAsyncCtrl[1] && syncCtrlOne[2] |=> pinOe[1] == $past(syncCtrlOne[6]))
		else $error("pin 1 clock direction wrong");
	rts_two_a: assert property (secondAsyncCtrl[6] |=> pinOe[3] && pinOut[3] == $past(secondAsyncOut.rts))
		else $error("pin 3 lost request to send");
	tx_one_a: assert property (firstAsyncCtrl[0] |=> pinOe[4] && pinOut[4] == $past(firstAsyncOut.txd))
		else $error("pin 4 lost first transmit");
	rx_one_a: assert property (firstAsyncCtrl[1] |=> !pinOe[5])
		else $error("pin 5 driven while receiving");
	rts_one_a: assert property (firstAsyncCtrl[6] |=> pinOe[7] && pinOut[7] == $past(firstAsyncOut.rts))
		else $error("pin 7 lost request to send");
	bus_strobe_a: assert property (busMode |=> busPins.oe && busPins.rdN == !$past(core.cpuRead)
		&& busPins.wrN == !$past(core.cpuWrite) && busPins.dmaActive == $past(core.dmaBusy))
		else $error("bus strobes wrong");
	phi_stop_a: assert property (busMode && core.stopOrWait |=> busPins.phiOut)
		else $error("clock output not held high");
	phi_run_a: assert property (busMode && !core.stopOrWait |=> busPins.phiOut != $past(busPins.phiOut))
		else $error("clock output not toggling");
	sync_pulse_a: assert property (fetchSeq |-> busPins.opcode_fetch_pulse ##1 !busPins.opcode_fetch_pulse)
		else $error("sync pulse wrong");
	mode_lock_a: assert property (lockedWrite |=> cpuMode[1] == $past(cpuMode[1]))
		else $error("mode bit 1 changed under strap");
	read_idle_a: assert property (!regRead |=> regRdData == 8'h00)
		else $error("read data outside read cycle");
endmodule

bind p8m_pin_ctrl p8m_chk i_chk (.clock(clock), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
	.regRead(regRead), .regRdData(regRdData), .pinOut(pinOut), .pinOe(pinOe), .modeStrapPin(modeStrapPin),
	.firstAsyncOut(firstAsyncOut), .secondAsyncOut(secondAsyncOut), .sioOut(sioOut), .syncCtrlOne(syncCtrlOne),
	.firstAsyncCtrl(firstAsyncCtrl), .secondAsyncCtrl(secondAsyncCtrl), .cpuMode(cpuMode), .core(core),
	.busPins(busPins));

// *** p8m_peer.sv ***
// partner: far devices on the port 8 wires
module p8m_peer (
	// block side of the wires
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	// level the far devices put on wires the block releases
	input wire logic [7:0] extVal,
	output logic [7:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule

// *** p8m_tb.sv ***
// testbench: scenarios for the port 8 pin control
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import p8m_pkg::*;
	logic clock = 0, srst = 1, regWrite = 0, regRead = 0, modeStrapPin = 1;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, pinIn, pinOut, pinOe, d;
	logic [7:0] syncCtrlOne, syncCtrlTwo, firstAsyncCtrl, secondAsyncCtrl;
	// far side level chosen with zeros on input pins 0, 2 and 5 so idle ones are told apart
	logic [7:0] extVal = 8'h5a;
	logic [1:0] cpuMode;
	p8m_async_out_t firstAsyncOut = 2'h2, secondAsyncOut = 2'h1;
	p8m_async_in_t firstAsyncIn, secondAsyncIn;
	p8m_sio_out_t sioOut = 3'h5;
	p8m_sio_in_t sioIn;
	p8m_core_t core = 5'h00;
	p8m_bus_pins_t busPins;
	int failures = 0, samples_checked = 0;
	p8m_pin_ctrl i_dut (.clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.modeStrapPin(modeStrapPin), .firstAsyncOut(firstAsyncOut), .secondAsyncOut(secondAsyncOut),
		.sioOut(sioOut), .firstAsyncIn(firstAsyncIn), .secondAsyncIn(secondAsyncIn), .sioIn(sioIn),
		.syncCtrlOne(syncCtrlOne), .syncCtrlTwo(syncCtrlTwo), .firstAsyncCtrl(firstAsyncCtrl),
		.secondAsyncCtrl(secondAsyncCtrl), .cpuMode(cpuMode), .core(core), .busPins(busPins));
	p8m_peer i_peer (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .pinIn(pinIn));
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic t_gpio;
		wr(OFS_PORT_DIR, 8'h0f);
		wr(OFS_PORT_DATA, 8'ha5);
		wait_n(1);
		check(pinOe, 8'h0f);
		check(pinOut & 8'h0f, 8'h05);
		rd(OFS_PORT_DATA);
		check(d, 8'h55);
		rd(8'h10);
		check(d, 8'h00);
	endtask
	task automatic t_pin_low;
		wr(OFS_PORT_DIR, 8'hff);
		wr(OFS_PORT_DATA, 8'h00);
		wr(OFS_SYNC_CTRL_ONE, 8'h5c);
		wait_n(1);
		check(pinOut, 8'h09);
		wr(OFS_SECOND_ASYNC_CTRL, 8'h43);
		wait_n(1);
		check(secondAsyncCtrl, 8'h43);
		check(pinOe, 8'hfd);
		check(pinOut & 8'hfd, 8'h08);
		wr(OFS_SECOND_ASYNC_CTRL, 8'h00);
		wr(OFS_SYNC_CTRL_ONE, 8'h14);
		wait_n(4);
		check(pinOe, 8'hfc);
		check(8'(sioIn), 8'h03);
		check(syncCtrlOne, 8'h14);
	endtask
	task automatic t_pin_high;
		wr(OFS_SYNC_CTRL_ONE, 8'h00);
		wr(OFS_FIRST_ASYNC_CTRL, 8'h63);
		wr(OFS_SECOND_ASYNC_CTRL, 8'h20);
		wr(OFS_SYNC_CTRL_TWO, 8'h04);
		wait_n(4);
		check(pinOe, 8'h9b);
		check(pinOut & 8'h9b, 8'h10);
		check({4'h0, firstAsyncIn, secondAsyncIn}, 8'h06);
		check(8'(sioIn), 8'h07);
		check(syncCtrlTwo, 8'h04);
		check(firstAsyncCtrl, 8'h63);
		wr(OFS_SECOND_ASYNC_CTRL, 8'h00);
		wait_n(4);
		check(8'(sioIn), 8'h06);
		check(secondAsyncCtrl, 8'h00);
		// pin 2 now serves the clocked receive, pins 4 to 7 the first unit
		rd(OFS_PIN_FUNC);
		check(d, 8'hf4);
	endtask
	task automatic t_bus;
		@(posedge clock);
		core <= 5'h16;
		@(posedge clock);
		core <= 5'h09;
		#1;
		check(8'(busPins) & 8'h37, 8'h35);
		wait_n(1);
		check(8'(busPins), 8'h2a);
		@(posedge clock);
		core <= 5'h00;
		wr(OFS_CPU_MODE_A, 8'h00);
		wait_n(0);
		check(8'(cpuMode), 8'(MODE_MICRO));
		rd(OFS_CPU_MODE_A);
		check(d, 8'h02);
	endtask
	task automatic t_strap_low;
		@(posedge clock);
		srst <= 1'b1;
		modeStrapPin <= 1'b0;
		repeat (RESET_MIN_CYC) @(posedge clock);
		srst <= 1'b0;
		wait_n(1);
		check(8'(cpuMode), 8'(MODE_SINGLE));
		check(8'(busPins.oe), 8'h00);
		wr(OFS_CPU_MODE_A, 8'h02);
		wait_n(0);
		check(8'(cpuMode), 8'(MODE_MICRO));
		// memory expansion mode also owns the bus control pins
		wr(OFS_CPU_MODE_A, 8'h01);
		wait_n(1);
		check(8'(cpuMode), 8'h01);
		check(8'(busPins.oe), 8'h01);
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		#1;
		check(pinOe, 8'h00);
		check(8'(cpuMode), 8'(MODE_MICRO));
		t_gpio;
		t_pin_low;
		t_pin_high;
		t_bus;
		t_strap_low;
		stop_test;
	end
	// the scenarios need some ninety cycles
	initial begin
		#500000;
		failures++;
		stop_test;
	end
endmodule
